// ===== cdd_pkg.sv
/*
 * constants shared by the compare/decrement decode slice: opcodes, prefix,
 * flag positions, fetch and execution cycle counts.
 * assumes the fetch unit hands over whole opcode bytes, prefix included.
 */
// Function
// - bit inversion 60/61 complements dst, keeps carry, sets Z S, clears V.
// - compare A2..A7 subtracts src from dst, no store, sets C Z S V.
// - prefix 1F before compare opcode adds carry borrow, one extra fetch cycle.
// - prefix 1F with A8/A9 is extended compare with borrow, 5 fetch 3 exec.
// - A8/A9 alone are extended compare, 4 fetch 3 exec, flags as compare.
// - decimal adjust 40/41 sets C Z S, V undefined, D H kept.
// - byte decrement 30/31, carry kept, Z S V from result.
// - word decrement 80/81, five or six exec cycles, carry kept, Z S V set.
// - opcode 8F clears interrupt enable bit 7, two exec cycles, flags kept.
// - opcode 9F sets interrupt enable bit 7, two exec cycles, flags kept.
// - xA opcodes decrement register x, branch if nonzero, three exec, no flags.
// - dash keeps flag, asterisk derives from result, X leaves it undefined.
package cdd_pkg;
   // ---------------------------------------------------------------
   // opcodes
   // ---------------------------------------------------------------
   localparam logic [7:0] OP_INVERT_R  = 8'h60;
   localparam logic [7:0] OP_INVERT_IR = 8'h61;
   localparam logic [7:0] OP_CMP_LO    = 8'ha2;
   localparam logic [7:0] OP_CMP_HI    = 8'ha7;
   localparam logic [7:0] OP_CMPX_RR   = 8'ha8;
   localparam logic [7:0] OP_CMPX_IM   = 8'ha9;
   localparam logic [7:0] OP_PREFIX    = 8'h1f;
   localparam logic [7:0] OP_DADJ_R    = 8'h40;
   localparam logic [7:0] OP_DADJ_IR   = 8'h41;
   localparam logic [7:0] OP_DECB_R    = 8'h30;
   localparam logic [7:0] OP_DECB_IR   = 8'h31;
   localparam logic [7:0] OP_WDEC_RR   = 8'h80;
   localparam logic [7:0] OP_WDEC_IRR  = 8'h81;
   localparam logic [7:0] OP_MASK      = 8'h8f;
   localparam logic [7:0] OP_UNMASK    = 8'h9f;
   localparam logic [3:0] OP_CDB_LOW   = 4'ha;
   localparam logic [7:0] CDB_LO       = 8'h0a;
   localparam logic [7:0] CDB_HI       = 8'hfa;
   // ---------------------------------------------------------------
   // flag positions in the flags byte: C Z S V D H
   // ---------------------------------------------------------------
   localparam int FL_C = 7;
   localparam int FL_Z = 6;
   localparam int FL_S = 5;
   localparam int FL_V = 4;
   localparam int FL_D = 3;
   localparam int FL_H = 2;
   localparam int IEN_BIT = 7;
   localparam logic [7:0] FLAGS_RST  = 8'h00;
   localparam logic [7:0] INTCTL_RST = 8'h00;
   localparam logic [7:0] DADJ_SIX   = 8'h06;
   localparam logic [7:0] DADJ_SIXTY = 8'h60;
   localparam logic [3:0] DADJ_NINE  = 4'h9;
   localparam logic [7:0] DADJ_99    = 8'h99;
   // ---------------------------------------------------------------
   // cycle counts
   // ---------------------------------------------------------------
   localparam logic [2:0] EX_2 = 3'h2;
   localparam logic [2:0] EX_3 = 3'h3;
   localparam logic [2:0] EX_4 = 3'h4;
   localparam logic [2:0] EX_5 = 3'h5;
   localparam logic [2:0] EX_6 = 3'h6;
   localparam logic [2:0] FE_1 = 3'h1;
   localparam logic [2:0] FE_2 = 3'h2;
   localparam logic [2:0] FE_3 = 3'h3;
   localparam logic [2:0] FE_4 = 3'h4;
   localparam logic [2:0] FE_5 = 3'h5;
   typedef enum {CDD_IDLE, CDD_PREFIXED, CDD_EXEC} cdd_state_e;
endpackage

// ===== cdd_alu.sv
/*
 * arithmetic for the decode slice: subtract with borrow, byte ops, word
 * decrement and decimal adjust, all combinational.
 * assumes operands are valid in the cycle the decoder latches them.
 */
`timescale 1ns/1ps
module cdd_alu (
   input  wire logic [2:0]  op_in,     // 0 cmp,1 inv,2 dadj,3 decb,4 wdec,5 cdb
   input  wire logic [15:0] dst_in,    // destination value
   input  wire logic [7:0]  src_in,    // source value
   input  wire logic        carry_in,  // borrow input
   input  wire logic        use_c_in,  // include carry in subtract
   input  wire logic        half_in,   // half carry for decimal adjust
   output logic      [15:0] res_out,   // result
   output logic             c_out,     // carry out
   output logic             v_out      // overflow out
);
   // ---------------------------------------------------------------
   // subtract path shared by compare and decrements
   // ---------------------------------------------------------------
   wire logic [7:0] sub_b   = (op_in == 3'd0) ? src_in : 8'h01;
   wire logic       bor     = (op_in == 3'd0) && use_c_in && carry_in;
   wire logic [8:0] diff    = {1'b0, dst_in[7:0]} - {1'b0, sub_b} - {8'h00, bor};
   wire logic [15:0] wdiff  = dst_in - 16'h0001;
   wire logic [7:0] inv     = ~dst_in[7:0];
   // decimal adjust after a subtraction-free add; correct low then high digit
   wire logic lo_fix = half_in || (dst_in[3:0] > cdd_pkg::DADJ_NINE);
   wire logic hi_fix = carry_in || (dst_in[7:0] > cdd_pkg::DADJ_99);
   wire logic [7:0] dadj = dst_in[7:0] + (lo_fix ? cdd_pkg::DADJ_SIX : 8'h00)
                         + (hi_fix ? cdd_pkg::DADJ_SIXTY : 8'h00);
   wire logic v_sub = (dst_in[7] != sub_b[7]) && (diff[7] != dst_in[7]);
   wire logic v_w   = dst_in[15] && !wdiff[15];
   // selection
   assign res_out = (op_in == 3'd1) ? {8'h00, inv} :
                    (op_in == 3'd2) ? {8'h00, dadj} :
                    (op_in == 3'd4) ? wdiff : {8'h00, diff[7:0]};
   assign c_out   = (op_in == 3'd2) ? hi_fix : diff[8];
   assign v_out   = (op_in == 3'd4) ? v_w : v_sub;
endmodule // cdd_alu

// ===== cdd_decoder.sv
/*
 * decode and execute slice for inversion, compare, compare with borrow,
 * extended compare, decimal adjust, byte/word decrement, count-down branch
 * and interrupt mask/unmask.
 * assumes the fetch unit presents one opcode byte per op_valid_in pulse and
 * supplies operands with it; the core writes results back from res_out.
 */
`timescale 1ns/1ps
module cdd_decoder (
   input  wire logic        clk_in,        // 50 MHz system clock
   input  wire logic        rst_n_in,      // synchronous reset, active low
   input  wire logic        op_valid_in,   // opcode byte offered
   input  wire logic [7:0]  opcode_in,     // opcode byte
   input  wire logic [15:0] dst_in,        // destination operand
   input  wire logic [7:0]  src_in,        // source operand
   output logic             op_ready_out,  // ready for an opcode, high whenever not executing
   output logic             pass_out,      // opcode not ours, handed on
   output logic             busy_out,      // executing
   output logic             done_out,      // one-cycle completion pulse
   output logic             wr_en_out,     // result is to be stored
   output logic             word_out,      // result is 16 bits
   output logic [15:0]      res_out,       // result value
   output logic [3:0]       reg_num_out,   // count-down register number
   output logic             branch_out,    // take relative branch
   output logic [2:0]       fetch_cyc_out, // fetch cycles of the instruction
   output logic [7:0]       flags_out,     // flags register
   output logic [7:0]       intctl_out     // interrupt_control_reg
);
   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   cdd_pkg::cdd_state_e state_r, state_nxt;
   logic [2:0] cnt_r;
   logic       pre_r;
   wire logic is_inv  = opcode_in == cdd_pkg::OP_INVERT_R || opcode_in == cdd_pkg::OP_INVERT_IR;
   wire logic is_cmp  = opcode_in >= cdd_pkg::OP_CMP_LO && opcode_in <= cdd_pkg::OP_CMP_HI;
   wire logic is_cmpx = opcode_in == cdd_pkg::OP_CMPX_RR || opcode_in == cdd_pkg::OP_CMPX_IM;
   wire logic is_dadj = opcode_in == cdd_pkg::OP_DADJ_R || opcode_in == cdd_pkg::OP_DADJ_IR;
   wire logic is_decb = opcode_in == cdd_pkg::OP_DECB_R || opcode_in == cdd_pkg::OP_DECB_IR;
   wire logic is_wdec = opcode_in == cdd_pkg::OP_WDEC_RR || opcode_in == cdd_pkg::OP_WDEC_IRR;
   wire logic is_mask = opcode_in == cdd_pkg::OP_MASK;
   wire logic is_unm  = opcode_in == cdd_pkg::OP_UNMASK;
   wire logic is_cdb  = opcode_in[3:0] == cdd_pkg::OP_CDB_LOW;
   wire logic is_pre  = opcode_in == cdd_pkg::OP_PREFIX;
   wire logic in_pre  = state_r == cdd_pkg::CDD_PREFIXED;
   // after a prefix only compares belong here
   wire logic ours    = in_pre ? (is_cmp || is_cmpx)
                      : (is_inv || is_cmp || is_cmpx || is_dadj || is_decb || is_wdec
                         || is_mask || is_unm || is_cdb || is_pre);
   wire logic idle    = state_r != cdd_pkg::CDD_EXEC;
   wire logic take    = op_valid_in && idle && ours;
   wire logic start   = take && !is_pre;
   assign op_ready_out = idle;
   assign pass_out     = op_valid_in && idle && !ours;
   assign busy_out     = !idle;
   // execution cycles per opcode; indirect forms carry opcode bit 0
   wire logic [2:0] ex_len =
        (is_cmp && !opcode_in[0])         ? cdd_pkg::EX_3 :
        is_cmp                            ? cdd_pkg::EX_4 :
        is_cmpx                           ? cdd_pkg::EX_3 :
        is_wdec                           ? (opcode_in[0] ? cdd_pkg::EX_6 : cdd_pkg::EX_5) :
        (is_mask || is_unm)               ? cdd_pkg::EX_2 :
        is_cdb                            ? cdd_pkg::EX_3 :
        opcode_in[0]                      ? cdd_pkg::EX_3 : cdd_pkg::EX_2;
   wire logic [2:0] fe_base =
        is_cmpx ? cdd_pkg::FE_4 :
        (is_cmp && opcode_in >= cdd_pkg::OP_CMP_LO + 8'h02) ? cdd_pkg::FE_3 :
        (is_mask || is_unm) ? cdd_pkg::FE_1 : cdd_pkg::FE_2;
   wire logic [2:0] fe_len = fe_base + (in_pre ? 3'h1 : 3'h0);
   // ---------------------------------------------------------------
   // arithmetic
   // ---------------------------------------------------------------
   wire logic [2:0] alu_op = (is_cmp || is_cmpx) ? 3'd0 : is_inv ? 3'd1 : is_dadj ? 3'd2 :
                             is_decb ? 3'd3 : is_wdec ? 3'd4 : 3'd5;
   logic [15:0] alu_res;
   logic        alu_c;
   logic        alu_v;
   cdd_alu u_alu (
      .op_in    (alu_op),
      .dst_in   (dst_in),
      .src_in   (src_in),
      .carry_in (flags_out[cdd_pkg::FL_C]),
      .use_c_in (in_pre),
      .half_in  (flags_out[cdd_pkg::FL_H]),
      .res_out  (alu_res),
      .c_out    (alu_c),
      .v_out    (alu_v)
   );
   wire logic res_zero = is_wdec ? (alu_res == 16'h0000) : (alu_res[7:0] == 8'h00);
   wire logic res_sign = is_wdec ? alu_res[15] : alu_res[7];
   // flag update: keep ('-') unless the opcode derives ('*') or fixes it
   logic [7:0] flags_new;
   always_comb begin
      flags_new = flags_out;
      if (is_inv) begin
         flags_new[cdd_pkg::FL_Z] = res_zero;
         flags_new[cdd_pkg::FL_S] = res_sign;
         flags_new[cdd_pkg::FL_V] = 1'b0;
      end else if (is_cmp || is_cmpx || is_decb || is_wdec) begin
         if (is_cmp || is_cmpx) begin
            flags_new[cdd_pkg::FL_C] = alu_c;
         end
         flags_new[cdd_pkg::FL_Z] = res_zero;
         flags_new[cdd_pkg::FL_S] = res_sign;
         flags_new[cdd_pkg::FL_V] = alu_v;
      end else if (is_dadj) begin
         flags_new[cdd_pkg::FL_C] = alu_c;
         flags_new[cdd_pkg::FL_Z] = res_zero;
         flags_new[cdd_pkg::FL_S] = res_sign;
         // overflow undefined: left as it was, which is a legal value
      end
   end
   // ---------------------------------------------------------------
   // state machine
   // ---------------------------------------------------------------
   always_comb begin
      case (state_r)
         cdd_pkg::CDD_IDLE,
         cdd_pkg::CDD_PREFIXED: begin
            if (take && is_pre && !in_pre) state_nxt = cdd_pkg::CDD_PREFIXED;
            else if (start) state_nxt = cdd_pkg::CDD_EXEC;
            else if (op_valid_in) state_nxt = cdd_pkg::CDD_IDLE;
            else state_nxt = state_r;
         end
         cdd_pkg::CDD_EXEC: state_nxt = (cnt_r == 3'h1) ? cdd_pkg::CDD_IDLE : cdd_pkg::CDD_EXEC;
         default: state_nxt = cdd_pkg::CDD_IDLE;
      endcase
   end
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         state_r <= cdd_pkg::CDD_IDLE;
         cnt_r   <= 3'h0;
         pre_r   <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= start ? ex_len - 3'h1 : (cnt_r != 3'h0 ? cnt_r - 3'h1 : 3'h0);
         pre_r   <= start ? in_pre : pre_r;
      end
   end
   // latch results at issue; done fires at the last execution cycle
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         flags_out     <= cdd_pkg::FLAGS_RST;
         intctl_out    <= cdd_pkg::INTCTL_RST;
         res_out       <= 16'h0000;
         wr_en_out     <= 1'b0;
         word_out      <= 1'b0;
         reg_num_out   <= 4'h0;
         branch_out    <= 1'b0;
         fetch_cyc_out <= 3'h0;
      end else if (start) begin
         flags_out     <= flags_new;
         if (is_mask) intctl_out[cdd_pkg::IEN_BIT] <= 1'b0;
         if (is_unm)  intctl_out[cdd_pkg::IEN_BIT] <= 1'b1;
         res_out       <= alu_res;
         // compares never store their difference
         wr_en_out     <= is_inv || is_dadj || is_decb || is_wdec || is_cdb;
         word_out      <= is_wdec;
         reg_num_out   <= opcode_in[7:4];
         branch_out    <= is_cdb && (alu_res[7:0] != 8'h00);
         fetch_cyc_out <= fe_len;
      end
   end
   assign done_out = (state_r == cdd_pkg::CDD_EXEC) && (cnt_r == 3'h1);

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   property p_inv_keeps_carry;
      @(posedge clk_in) disable iff (!rst_n_in)
      start && is_inv |=> flags_out[cdd_pkg::FL_C] == $past(flags_out[cdd_pkg::FL_C])
                          && !flags_out[cdd_pkg::FL_V];
   endproperty
   a_inv_keeps_carry: assert property (p_inv_keeps_carry) else $error("inversion flags");
   property p_cmp_nostore;
      @(posedge clk_in) disable iff (!rst_n_in)
      start && (is_cmp || is_cmpx) |=> !wr_en_out ##[1:2] done_out;
   endproperty
   a_cmp_nostore: assert property (p_cmp_nostore) else $error("compare stored");
   property p_pre_fetch;
      @(posedge clk_in) disable iff (!rst_n_in)
      start && in_pre && is_cmp |=> fetch_cyc_out ==
         (($past(opcode_in) >= cdd_pkg::OP_CMP_LO + 8'h02) ? cdd_pkg::FE_4 : cdd_pkg::FE_3);
   endproperty
   a_pre_fetch: assert property (p_pre_fetch) else $error("prefix fetch count");
   property p_cmpx_cycles;
      @(posedge clk_in) disable iff (!rst_n_in)
      start && is_cmpx |=> fetch_cyc_out == (pre_r ? cdd_pkg::FE_5 : cdd_pkg::FE_4)
                           ##1 done_out;
   endproperty
   a_cmpx_cycles: assert property (p_cmpx_cycles) else $error("extended compare");
   property p_wdec_len;
      @(posedge clk_in) disable iff (!rst_n_in)
      start && opcode_in == cdd_pkg::OP_WDEC_IRR |=> !done_out [*4] ##1 done_out;
   endproperty
   a_wdec_len: assert property (p_wdec_len) else $error("word decrement length");
   property p_mask;
      @(posedge clk_in) disable iff (!rst_n_in)
      start && is_mask |=> !intctl_out[cdd_pkg::IEN_BIT] && $stable(flags_out) ##0 done_out;
   endproperty
   a_mask: assert property (p_mask) else $error("mask interrupts");
   property p_unmask;
      @(posedge clk_in) disable iff (!rst_n_in)
      start && is_unm |=> intctl_out[cdd_pkg::IEN_BIT] && $stable(flags_out);
   endproperty
   a_unmask: assert property (p_unmask) else $error("unmask interrupts");
   property p_cdb_flags;
      @(posedge clk_in) disable iff (!rst_n_in)
      start && is_cdb && !is_cmp |=> $stable(flags_out) ##1 done_out;
   endproperty
   a_cdb_flags: assert property (p_cdb_flags) else $error("count-down flags");
   property p_pass;
      @(posedge clk_in) disable iff (!rst_n_in)
      pass_out |=> state_r == cdd_pkg::CDD_IDLE && $stable(flags_out) && $stable(intctl_out);
   endproperty
   a_pass: assert property (p_pass) else $error("foreign opcode side effect");
   // byte decrement stores its result but must not touch carry
   property p_decb_carry;
      @(posedge clk_in) disable iff (!rst_n_in)
      start && is_decb |=> flags_out[cdd_pkg::FL_C] == $past(flags_out[cdd_pkg::FL_C])
                           && wr_en_out;
   endproperty
   a_decb_carry: assert property (p_decb_carry) else $error("byte decrement carry");
   // decimal adjust keeps the decimal and half-carry bits
   property p_dadj_keep;
      @(posedge clk_in) disable iff (!rst_n_in)
      start && is_dadj |=> flags_out[cdd_pkg::FL_D] == $past(flags_out[cdd_pkg::FL_D])
                           && flags_out[cdd_pkg::FL_H] == $past(flags_out[cdd_pkg::FL_H])
                           && wr_en_out;
   endproperty
   a_dadj_keep: assert property (p_dadj_keep) else $error("decimal adjust flags");
endmodule // cdd_decoder

// ===== cdd_fetch_model.sv
/*
 * model of the core's fetch unit: offers one opcode byte with its operands,
 * optionally behind the prefix byte, and reports when the decoder consumed it.
 * assumes the bench asks for a new instruction only while the model is idle.
 */
`timescale 1ns/1ps
module cdd_fetch_model (
   input  wire logic        clk_in,       // system clock
   input  wire logic        rst_n_in,     // synchronous reset, active low
   input  wire logic        req_in,       // bench asks for one instruction
   input  wire logic        req_pre_in,   // send the prefix byte first
   input  wire logic [7:0]  req_op_in,    // opcode to send
   input  wire logic [15:0] req_dst_in,   // destination operand
   input  wire logic [7:0]  req_src_in,   // source operand
   input  wire logic        op_ready_in,  // decoder ready
   input  wire logic        pass_in,      // decoder handed the byte on
   output logic             op_valid_out, // byte offered
   output logic [7:0]       opcode_out,   // offered byte
   output logic [15:0]      dst_out,      // destination operand
   output logic [7:0]       src_out,      // source operand
   output logic             taken_out,    // last byte consumed, one cycle
   output logic             passed_out    // that byte was handed on
);
   // ---------------------------------------------------------------
   // offer and hold
   // ---------------------------------------------------------------
   logic        valid_r = 1'b0;
   logic        pre_r   = 1'b0;
   logic [7:0]  op_r    = 8'h00;
   logic [15:0] dst_r   = 16'h0000;
   logic [7:0]  src_r   = 8'h00;

   // an offer is held until an edge with ready high; the prefix byte goes first
   always_ff @(posedge clk_in) begin
      taken_out <= 1'b0;
      if (!rst_n_in) begin
         valid_r    <= 1'b0;
         pre_r      <= 1'b0;
         passed_out <= 1'b0;
      end else if (valid_r && op_ready_in) begin
         pre_r      <= 1'b0;
         valid_r    <= pre_r;
         taken_out  <= !pre_r;
         passed_out <= pass_in;
      end else if (!valid_r && req_in) begin
         valid_r <= 1'b1;
         pre_r   <= req_pre_in;
         op_r    <= req_op_in;
         dst_r   <= req_dst_in;
         src_r   <= req_src_in;
      end
   end

   // between offers the lines show the inverse of the last value, so a
   // decoder that samples stale operands does not get them for free
   assign op_valid_out = valid_r;
   assign opcode_out   = !valid_r ? ~op_r : (pre_r ? cdd_pkg::OP_PREFIX : op_r);
   assign dst_out      = valid_r ? dst_r : ~dst_r;
   assign src_out      = valid_r ? src_r : ~src_r;
endmodule // cdd_fetch_model

// ===== cdd_decoder_tb.sv
/*
 * self-checking bench for the decode slice: the fetch model feeds opcodes,
 * each opcode sent through the run task checks result, flags and cycle counts.
 * assumes one opcode per valid/ready edge and done one cycle at the end.
 */
`timescale 1ns/1ps
module cdd_decoder_tb;
   // ---------------------------------------------------------------
   // signals and instances
   // ---------------------------------------------------------------
   logic        clk_in   = 1'b0;
   logic        rst_n_in = 1'b0;
   logic        req      = 1'b0;
   logic        req_pre  = 1'b0;
   logic [7:0]  req_op   = 8'h00;
   logic [15:0] req_dst  = 16'h0000;
   logic [7:0]  req_src  = 8'h00;
   logic        op_valid, op_ready, pass, busy, done, wr_en, word, branch, taken, passed;
   logic [7:0]  opcode, src, flags, intctl;
   logic [15:0] dst, res;
   logic [3:0]  reg_num;
   logic [2:0]  fetch_cyc;
   int          mismatches = 0;
   int          compares   = 0;

   cdd_fetch_model fetch (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .req_in(req), .req_pre_in(req_pre),
      .req_op_in(req_op), .req_dst_in(req_dst), .req_src_in(req_src),
      .op_ready_in(op_ready), .pass_in(pass), .op_valid_out(op_valid), .opcode_out(opcode),
      .dst_out(dst), .src_out(src), .taken_out(taken), .passed_out(passed)
   );
   cdd_decoder uut (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .op_valid_in(op_valid), .opcode_in(opcode),
      .dst_in(dst), .src_in(src), .op_ready_out(op_ready), .pass_out(pass), .busy_out(busy),
      .done_out(done), .wr_en_out(wr_en), .word_out(word), .res_out(res),
      .reg_num_out(reg_num), .branch_out(branch), .fetch_cyc_out(fetch_cyc),
      .flags_out(flags), .intctl_out(intctl)
   );

   // 50 MHz
   initial begin
      forever #10 clk_in = ~clk_in;
   end

   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic conclude;
      $display("comparisons %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // a wait that ran out counts against the design and ends the run
   task automatic stall(input string what);
      mismatches++;
      $display("CHECK FAILED %s expected response seen none", what);
      conclude;
   endtask

   // ask the fetch model for one instruction; returns just after the take edge
   task automatic issue(input logic pre, input logic [7:0] op, input logic [15:0] d,
                        input logic [7:0] s);
      int k;
      @(posedge clk_in);
      req     <= 1'b1;
      req_pre <= pre;
      req_op  <= op;
      req_dst <= d;
      req_src <= s;
      @(posedge clk_in);
      req <= 1'b0;
      k = 0;
      #1;
      while (taken !== 1'b1) begin
         if (k == 20) stall("take");
         @(posedge clk_in);
         #1;
         k++;
      end
   endtask

   // the first cycle after the take counts as execution cycle two
   task automatic run(input logic pre, input logic [7:0] op, input logic [15:0] d,
                      input logic [7:0] s, input logic [2:0] ex, input logic [2:0] fe,
                      input logic [15:0] r, input logic [15:0] rm, input logic [7:0] fl,
                      input logic [7:0] fm);
      logic [2:0] k;
      issue(pre, op, d, s);
      k = 3'h2;
      while (done !== 1'b1) begin
         if (k == 3'h7) stall("done");
         @(posedge clk_in);
         #1;
         k++;
      end
      check("exec cycles", {13'h0, k}, {13'h0, ex});
      check("fetch cycles", {13'h0, fetch_cyc}, {13'h0, fe});
      check("result", res & rm, r & rm);
      check("flags", {8'h00, flags & fm}, {8'h00, fl & fm});
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset;
      check("flags after reset", {8'h00, flags}, 16'h0000);
      check("irq control after reset", {8'h00, intctl}, 16'h0000);
      check("ready after reset", {15'h0, op_ready}, 16'h0001);
   endtask

   // plain forms leave carry set, so the borrowing forms see 0x10-0x20-1
   task automatic t_compare;
      logic [2:0] fe_t [8] = '{3'h2, 3'h2, 3'h3, 3'h3, 3'h3, 3'h3, 3'h4, 3'h4};
      logic [2:0] ex_t [8] = '{3'h3, 3'h4, 3'h3, 3'h4, 3'h3, 3'h4, 3'h3, 3'h3};
      logic [7:0] op;
      logic [2:0] fe;
      for (int i = 0; i < 16; i++) begin
         op = 8'ha2 + 8'(i[2:0]);
         fe = fe_t[i[2:0]] + 3'(i[3]);
         run(i[3], op, 16'h0010, 8'h20, ex_t[i[2:0]], fe, 16'h0, 16'h0, 8'ha0, 8'hff);
         check("compare store", {15'h0, wr_en}, 16'h0000);
      end
   endtask

   // overflow is set by the decrement first, so its clearing by inversion shows
   task automatic t_invert;
      run(1'b0, 8'h30, 16'h0080, 8'h00, 3'h2, 3'h2, 16'h007f, 16'h00ff, 8'h90, 8'hff);
      run(1'b0, 8'h60, 16'h005a, 8'h00, 3'h2, 3'h2, 16'h00a5, 16'h00ff, 8'ha0, 8'hff);
      run(1'b0, 8'h61, 16'h00ff, 8'h00, 3'h3, 3'h2, 16'h0000, 16'h00ff, 8'hc0, 8'hff);
      run(1'b1, 8'ha2, 16'h0020, 8'h1f, 3'h3, 3'h3, 16'h0000, 16'h0000, 8'h40, 8'hff);
   endtask

   // overflow is left out of the flag compare after a decimal adjust
   task automatic t_adjust_sub;
      run(1'b0, 8'h40, 16'h009a, 8'h00, 3'h2, 3'h2, 16'h0000, 16'h00ff, 8'hc0, 8'hef);
      run(1'b0, 8'h41, 16'h0099, 8'h00, 3'h3, 3'h2, 16'h00f9, 16'h00ff, 8'ha0, 8'hef);
      run(1'b0, 8'h31, 16'h0001, 8'h00, 3'h3, 3'h2, 16'h0000, 16'h00ff, 8'hc0, 8'hff);
      run(1'b0, 8'h80, 16'h0001, 8'h00, 3'h5, 3'h2, 16'h0000, 16'hffff, 8'hc0, 8'hff);
      check("word result", {15'h0, word}, 16'h0001);
      run(1'b0, 8'h81, 16'h8000, 8'h00, 3'h6, 3'h2, 16'h7fff, 16'hffff, 8'h90, 8'hff);
   endtask

   task automatic t_count_down;
      logic [7:0] op;
      for (int i = 0; i < 16; i++) begin
         op = {4'(i), 4'ha};
         run(1'b0, op, 16'h0005, 8'h00, 3'h3, 3'h2, 16'h0004, 16'h00ff, 8'h90, 8'hff);
         check("branch", {15'h0, branch}, 16'h0001);
         check("register number", {12'h0, reg_num}, {12'h0, op[7:4]});
         check("count-down store", {15'h0, wr_en}, 16'h0001);
      end
      run(1'b0, 8'h5a, 16'h0001, 8'h00, 3'h3, 3'h2, 16'h0000, 16'h00ff, 8'h90, 8'hff);
      check("branch at zero", {15'h0, branch}, 16'h0000);
   endtask

   task automatic t_mask;
      run(1'b0, 8'h9f, 16'h0000, 8'h00, 3'h2, 3'h1, 16'h0, 16'h0, 8'h90, 8'hff);
      check("enable set", {8'h00, intctl}, 16'h0080);
      run(1'b0, 8'h8f, 16'h0000, 8'h00, 3'h2, 3'h1, 16'h0, 16'h0, 8'h90, 8'hff);
      check("enable cleared", {8'h00, intctl}, 16'h0000);
   endtask

   // a prefix in front of a non-compare byte is dropped and the byte handed on
   task automatic t_pass;
      issue(1'b0, 8'h00, 16'h0001, 8'h00);
      check("handed on", {15'h0, passed}, 16'h0001);
      issue(1'b1, 8'h30, 16'h0001, 8'h00);
      check("handed on after prefix", {15'h0, passed}, 16'h0001);
      repeat (3) @(posedge clk_in);
      #1;
      check("no execution", {15'h0, busy}, 16'h0000);
      check("flags kept", {8'h00, flags}, 16'h0090);
   endtask

   initial begin
      repeat (16) @(posedge clk_in);
      rst_n_in <= 1'b1;
      @(posedge clk_in);
      #1;
      t_reset;
      t_compare;
      t_invert;
      t_adjust_sub;
      t_count_down;
      t_mask;
      t_pass;
      conclude;
   end
endmodule // cdd_decoder_tb
